/* hdl/otcps_char_store.sv */
`timescale 1ns/1ps
`default_nettype none
// character property entry: property registers, commit, cursor and render port
module otcps_char_store #(
  parameter int DEPTH = otcps_pkg::MAX_ELEMS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port from the serial control bus front end
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  // element commit indication
  output logic elem_committed,
  // renderer port
  input wire logic render_req,
  input wire logic [otcps_pkg::ADDR_BITS-1:0] render_addr,
  output otcps_pkg::otcps_render_t render_attr,
  output logic render_valid,
  // global blend factors
  output logic [7:0] back_blend_factor,
  output logic [7:0] fore_blend_factor
);

  // refuse a window larger than the element store can address
  if (DEPTH < 1 || DEPTH > otcps_pkg::MAX_ELEMS) begin
    $error("window depth out of range");
  end

  typedef struct packed {
    logic [7:0] char_attr_flags;
    logic [7:0] char_colour_and_font_select;
    logic [7:0] char_code_low_byte;
    logic [7:0] attribute_update_filter;
    logic [7:0] cursor_column;
    logic [7:0] cursor_row;
    logic [7:0] window_cols;
    logic [7:0] window_rows;
    logic [7:0] multicolour_boundary_high;
    logic [7:0] multicolour_boundary_low;
    logic [7:0] back_blend_factor;
    logic [7:0] fore_blend_factor;
    logic [2:0] written;
    logic [7:0] rd_data;
    logic rd_valid;
    logic committed;
    logic render_pend;
    logic render_valid;
    otcps_pkg::otcps_render_t render_attr;
  } otcps_top_st_t;

  otcps_top_st_t st_r;
  otcps_top_st_t st_nxt;

  // combinational helpers
  logic [2:0] write_mode;
  logic [2:0] hit;
  logic [2:0] written_now;
  logic commit_now;
  otcps_pkg::otcps_elem_t elem_now;
  otcps_pkg::otcps_elem_t bit_en;
  logic [15:0] lin_addr;
  logic [otcps_pkg::ADDR_BITS-1:0] cursor_addr;
  logic col_end;
  logic row_end;
  otcps_pkg::otcps_elem_t ram_rd;
  otcps_pkg::otcps_render_t decoded;
  logic [8:0] boundary;

  assign write_mode = st_r.attribute_update_filter[otcps_pkg::FLT_MODE_LSB +: 3];
  assign boundary = {st_r.multicolour_boundary_high[0], st_r.multicolour_boundary_low};

  // which property register the current write lands on
  always_comb begin
    hit = 3'h0;
    if (reg_wr_en) begin
      if (reg_addr == otcps_pkg::OFS_CODE_LOW) begin
        hit[otcps_pkg::WM_CODE_LOW] = 1'b1;
      end else if (reg_addr == otcps_pkg::OFS_COLOUR_FONT) begin
        hit[otcps_pkg::WM_COLOUR_FONT] = 1'b1;
      end else if (reg_addr == otcps_pkg::OFS_ATTR_FLAGS) begin
        hit[otcps_pkg::WM_ATTR_FLAGS] = 1'b1;
      end
    end
  end

  // commit once every register enabled by the write mode has been written
  assign written_now = st_r.written | (hit & write_mode);
  assign commit_now = (|(hit & write_mode)) && ((written_now & write_mode) == write_mode);

  // element assembled from the register values after this write
  always_comb begin
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] p0;
    p2 = hit[otcps_pkg::WM_ATTR_FLAGS] ? reg_wr_data : st_r.char_attr_flags;
    p1 = hit[otcps_pkg::WM_COLOUR_FONT] ? reg_wr_data : st_r.char_colour_and_font_select;
    p0 = hit[otcps_pkg::WM_CODE_LOW] ? reg_wr_data : st_r.char_code_low_byte;
    // 23 bits: flags byte minus its top bit, middle byte, low byte
    elem_now = otcps_pkg::otcps_elem_t'({p2[6:0], p1, p0});
  end

  // per-group write enables from the update filter
  always_comb begin
    logic [7:0] f;
    f = st_r.attribute_update_filter;
    bit_en = '0;
    bit_en.blink = otcps_pkg::otcps_blink_t'({2{f[otcps_pkg::FLT_BLINK]}});
    bit_en.shadow = f[otcps_pkg::FLT_SHADOW];
    bit_en.back_see_through = f[otcps_pkg::FLT_BACK];
    bit_en.back_blend_on = f[otcps_pkg::FLT_BACK];
    bit_en.back_colour_index = {3{f[otcps_pkg::FLT_BACK]}};
    bit_en.fore_see_through = f[otcps_pkg::FLT_FORE];
    bit_en.fore_blend_on = f[otcps_pkg::FLT_FORE];
    bit_en.fore_colour_index = {3{f[otcps_pkg::FLT_FORE]}};
    bit_en.font_rom = f[otcps_pkg::FLT_CODE];
    bit_en.char_code = {9{f[otcps_pkg::FLT_CODE]}};
  end

  // cursor to linear element address, row major
  assign lin_addr = 16'(st_r.cursor_row) * 16'(st_r.window_cols) + 16'(st_r.cursor_column);
  assign cursor_addr = lin_addr[otcps_pkg::ADDR_BITS-1:0];
  assign col_end = ({1'b0, st_r.cursor_column} + 9'h001) >= {1'b0, st_r.window_cols};
  assign row_end = ({1'b0, st_r.cursor_row} + 9'h001) >= {1'b0, st_r.window_rows};

  otcps_window_ram #(
    .DEPTH(DEPTH)
  ) u_ram (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(commit_now),
    .wr_addr(cursor_addr),
    .wr_data(elem_now),
    .wr_bit_en(bit_en),
    .rd_addr(render_addr),
    .rd_data(ram_rd)
  );

  otcps_elem_decode u_dec (
    .elem(ram_rd),
    .boundary(boundary),
    .attr(decoded)
  );

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.committed = commit_now;
    st_nxt.rd_valid = reg_rd_en;
    st_nxt.render_pend = render_req;
    st_nxt.render_valid = st_r.render_pend;
    if (st_r.render_pend) begin
      st_nxt.render_attr = decoded;
    end
    // register writes
    if (reg_wr_en) begin
      if (reg_addr == otcps_pkg::OFS_ATTR_FLAGS) begin
        st_nxt.char_attr_flags = {1'b0, reg_wr_data[6:0]};
      end else if (reg_addr == otcps_pkg::OFS_COLOUR_FONT) begin
        st_nxt.char_colour_and_font_select = reg_wr_data;
      end else if (reg_addr == otcps_pkg::OFS_CODE_LOW) begin
        st_nxt.char_code_low_byte = reg_wr_data;
      end else if (reg_addr == otcps_pkg::OFS_UPDATE_FILTER) begin
        st_nxt.attribute_update_filter = reg_wr_data;
      end else if (reg_addr == otcps_pkg::OFS_CURSOR_COLUMN) begin
        st_nxt.cursor_column = reg_wr_data;
      end else if (reg_addr == otcps_pkg::OFS_CURSOR_ROW) begin
        st_nxt.cursor_row = reg_wr_data;
      end else if (reg_addr == otcps_pkg::OFS_WINDOW_COLS) begin
        st_nxt.window_cols = reg_wr_data;
      end else if (reg_addr == otcps_pkg::OFS_WINDOW_ROWS) begin
        st_nxt.window_rows = reg_wr_data;
      end else if (reg_addr == otcps_pkg::OFS_BOUNDARY_HIGH) begin
        st_nxt.multicolour_boundary_high = {7'h00, reg_wr_data[0]};
      end else if (reg_addr == otcps_pkg::OFS_BOUNDARY_LOW) begin
        st_nxt.multicolour_boundary_low = reg_wr_data;
      end else if (reg_addr == otcps_pkg::OFS_BACK_BLEND) begin
        st_nxt.back_blend_factor = reg_wr_data;
      end else if (reg_addr == otcps_pkg::OFS_FORE_BLEND) begin
        st_nxt.fore_blend_factor = reg_wr_data;
      end
    end
    // progress of the current element; a new write mode restarts it
    if (reg_wr_en && reg_addr == otcps_pkg::OFS_UPDATE_FILTER) begin
      st_nxt.written = 3'h0;
    end else if (commit_now) begin
      st_nxt.written = 3'h0;
    end else begin
      st_nxt.written = written_now;
    end
    // cursor auto-increment after commit
    if (commit_now) begin
      if (!col_end) begin
        st_nxt.cursor_column = st_r.cursor_column + 8'h01;
      end else begin
        st_nxt.cursor_column = 8'h00;
        st_nxt.cursor_row = row_end ? 8'h00 : st_r.cursor_row + 8'h01;
      end
    end
    // register reads
    if (reg_rd_en) begin
      if (reg_addr == otcps_pkg::OFS_ATTR_FLAGS) begin
        st_nxt.rd_data = st_r.char_attr_flags;
      end else if (reg_addr == otcps_pkg::OFS_COLOUR_FONT) begin
        st_nxt.rd_data = st_r.char_colour_and_font_select;
      end else if (reg_addr == otcps_pkg::OFS_CODE_LOW) begin
        st_nxt.rd_data = st_r.char_code_low_byte;
      end else if (reg_addr == otcps_pkg::OFS_UPDATE_FILTER) begin
        st_nxt.rd_data = st_r.attribute_update_filter;
      end else if (reg_addr == otcps_pkg::OFS_CURSOR_COLUMN) begin
        st_nxt.rd_data = st_r.cursor_column;
      end else if (reg_addr == otcps_pkg::OFS_CURSOR_ROW) begin
        st_nxt.rd_data = st_r.cursor_row;
      end else if (reg_addr == otcps_pkg::OFS_WINDOW_COLS) begin
        st_nxt.rd_data = st_r.window_cols;
      end else if (reg_addr == otcps_pkg::OFS_WINDOW_ROWS) begin
        st_nxt.rd_data = st_r.window_rows;
      end else if (reg_addr == otcps_pkg::OFS_BOUNDARY_HIGH) begin
        st_nxt.rd_data = st_r.multicolour_boundary_high;
      end else if (reg_addr == otcps_pkg::OFS_BOUNDARY_LOW) begin
        st_nxt.rd_data = st_r.multicolour_boundary_low;
      end else if (reg_addr == otcps_pkg::OFS_BACK_BLEND) begin
        st_nxt.rd_data = st_r.back_blend_factor;
      end else if (reg_addr == otcps_pkg::OFS_FORE_BLEND) begin
        st_nxt.rd_data = st_r.fore_blend_factor;
      end else begin
        st_nxt.rd_data = 8'h00;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.char_attr_flags <= otcps_pkg::RST_PROP;
      st_r.char_colour_and_font_select <= otcps_pkg::RST_PROP;
      st_r.char_code_low_byte <= otcps_pkg::RST_PROP;
      st_r.attribute_update_filter <= otcps_pkg::RST_FILTER;
      st_r.window_cols <= otcps_pkg::RST_WINDOW_COLS;
      st_r.window_rows <= otcps_pkg::RST_WINDOW_ROWS;
      st_r.multicolour_boundary_high <= otcps_pkg::RST_BOUNDARY_HIGH;
      st_r.multicolour_boundary_low <= otcps_pkg::RST_BOUNDARY_LOW;
      st_r.back_blend_factor <= otcps_pkg::RST_BLEND;
      st_r.fore_blend_factor <= otcps_pkg::RST_BLEND;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rd_data = st_r.rd_data;
  assign reg_rd_valid = st_r.rd_valid;
  assign elem_committed = st_r.committed;
  assign render_attr = st_r.render_attr;
  assign render_valid = st_r.render_valid;
  assign back_blend_factor = st_r.back_blend_factor;
  assign fore_blend_factor = st_r.fore_blend_factor;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_column_step: assert property (commit_now && !col_end |=>
      st_r.cursor_column == $past(st_r.cursor_column) + 8'h01 && st_r.cursor_row == $past(st_r.cursor_row))
    else $error("cursor column did not step after commit");

  chk_row_step: assert property (commit_now && col_end && !row_end |=>
      st_r.cursor_column == 8'h00 && st_r.cursor_row == $past(st_r.cursor_row) + 8'h01)
    else $error("cursor did not move to next row start");

  chk_wrap_origin: assert property (commit_now && col_end && row_end |=>
      st_r.cursor_column == 8'h00 && st_r.cursor_row == 8'h00)
    else $error("cursor did not wrap to origin");

  chk_cursor_readback: assert property (reg_rd_en && reg_addr == otcps_pkg::OFS_CURSOR_ROW |=>
      reg_rd_valid && reg_rd_data == $past(st_r.cursor_row))
    else $error("cursor row read back wrong");

  chk_commit_complete: assert property (commit_now |->
      write_mode != 3'h0 && (((st_r.written | hit) & write_mode) == write_mode))
    else $error("commit before all enabled registers were written");

  chk_single_reg_mode: assert property (reg_wr_en && reg_addr == otcps_pkg::OFS_CODE_LOW
      && write_mode == 3'h1 |-> commit_now ##1 elem_committed)
    else $error("low byte write in low-byte mode did not commit");

  chk_filter_code: assert property (commit_now && !st_r.attribute_update_filter[otcps_pkg::FLT_CODE]
      |-> bit_en.char_code == 9'h000 && !bit_en.font_rom)
    else $error("masked code group would be written");

  chk_render_latency: assert property (render_req |-> ##2 render_valid)
    else $error("render answer not two cycles after request");

  chk_render_quiet: assert property (!render_req |-> ##2 !render_valid)
    else $error("render answer without a request");

endmodule
`default_nettype wire

/* hdl/otcps_pkg.sv */
// How it works
// - each committed element moves the cursor right, or to the next row start, or back to the origin after the last element.
// - host may read both cursor values at any time, even mid-burst.
// - every window element stores 23 property bits for its one character only.
// - three byte registers hold flags, colours plus font select plus code msb, code low.
// - blink field: 00 off, 01 foreground blinks, 10 inverse, 11 swap blinking.
// - shadow flag set draws the character with a one pixel diagonal shadow.
// - back see-through flag shows picture instead of background colour.
// - fore see-through flag shows picture instead of foreground colour.
// - back blend flag blends background with picture by global back factor.
// - fore blend flag blends foreground with picture by global fore factor.
// - three-bit background index picks one of eight table colours.
// - foreground field picks a colour, or a palette for multicolour characters.
// - each palette gives one background and three foreground colours.
// - for font ram characters, code compared with programmed boundary decides single or multicolour; font rom characters are single colour.
// - font source bit 1 fetches glyph from rom, 0 from ram.
// - nine-bit code, msb in middle register, low byte in lowest register.
// - commit and advance only after all registers enabled by write mode are written.
// - on commit each attribute group is written only if its filter bit is set.
`default_nettype none
package otcps_pkg;

  // element geometry
  localparam int ELEM_BITS = 23;
  localparam int ADDR_BITS = 10;
  localparam int MAX_ELEMS = 1024;

  // register map (byte sub-addresses)
  localparam logic [7:0] OFS_ATTR_FLAGS = 8'h00;
  localparam logic [7:0] OFS_COLOUR_FONT = 8'h01;
  localparam logic [7:0] OFS_CODE_LOW = 8'h02;
  localparam logic [7:0] OFS_UPDATE_FILTER = 8'h03;
  localparam logic [7:0] OFS_CURSOR_COLUMN = 8'h04;
  localparam logic [7:0] OFS_CURSOR_ROW = 8'h05;
  localparam logic [7:0] OFS_WINDOW_COLS = 8'h06;
  localparam logic [7:0] OFS_WINDOW_ROWS = 8'h07;
  localparam logic [7:0] OFS_BOUNDARY_HIGH = 8'h08;
  localparam logic [7:0] OFS_BOUNDARY_LOW = 8'h09;
  localparam logic [7:0] OFS_BACK_BLEND = 8'h0a;
  localparam logic [7:0] OFS_FORE_BLEND = 8'h0b;

  // update filter field positions
  localparam int FLT_BLINK = 7;
  localparam int FLT_SHADOW = 6;
  localparam int FLT_BACK = 5;
  localparam int FLT_FORE = 4;
  localparam int FLT_CODE = 3;
  localparam int FLT_MODE_LSB = 0;

  // write mode bits: which property register takes part in a commit
  localparam int WM_CODE_LOW = 0;
  localparam int WM_COLOUR_FONT = 1;
  localparam int WM_ATTR_FLAGS = 2;

  // reset values
  localparam logic [7:0] RST_PROP = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'hff;
  localparam logic [7:0] RST_WINDOW_COLS = 8'h20;
  localparam logic [7:0] RST_WINDOW_ROWS = 8'h10;
  localparam logic [7:0] RST_BOUNDARY_HIGH = 8'h01;
  localparam logic [7:0] RST_BOUNDARY_LOW = 8'h00;
  localparam logic [7:0] RST_BLEND = 8'h80;

  // read pipeline depth of the render port
  localparam int RENDER_LATENCY = 2;

  // blink modes
  typedef enum logic [1:0] {
    OTCPS_BLINK_OFF = 2'h0,
    OTCPS_BLINK_FORE = 2'h1,
    OTCPS_BLINK_INVERSE = 2'h2,
    OTCPS_BLINK_SWAP = 2'h3
  } otcps_blink_t;

  // one window element, msb first
  typedef struct packed {
    otcps_blink_t blink;
    logic shadow;
    logic back_see_through;
    logic fore_see_through;
    logic back_blend_on;
    logic fore_blend_on;
    logic [2:0] back_colour_index;
    logic [2:0] fore_colour_index;
    logic font_rom;
    logic [8:0] char_code;
  } otcps_elem_t;

  // decoded element for the renderer
  typedef struct packed {
    logic fore_blink;
    logic inverse;
    logic swap_blink;
    logic shadow_on;
    logic back_see_through;
    logic fore_see_through;
    logic back_blend_on;
    logic fore_blend_on;
    logic [2:0] back_colour_index;
    logic multicolour;
    logic [2:0] fore_colour_index;
    logic [2:0] palette_index;
    logic font_rom;
    logic [8:0] char_code;
  } otcps_render_t;

endpackage
`default_nettype wire

/* hdl/otcps_window_ram.sv */
`timescale 1ns/1ps
`default_nettype none
// window element store with per-bit write enable and registered read
module otcps_window_ram #(
  parameter int DEPTH = otcps_pkg::MAX_ELEMS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [otcps_pkg::ADDR_BITS-1:0] wr_addr,
  input wire otcps_pkg::otcps_elem_t wr_data,
  input wire otcps_pkg::otcps_elem_t wr_bit_en,
  // read port
  input wire logic [otcps_pkg::ADDR_BITS-1:0] rd_addr,
  output otcps_pkg::otcps_elem_t rd_data
);

  // refuse a depth that the address width cannot reach
  if (DEPTH < 1 || DEPTH > (1 << otcps_pkg::ADDR_BITS)) begin
    $error("window depth out of range");
  end

  otcps_pkg::otcps_elem_t mem [DEPTH];
  otcps_pkg::otcps_elem_t rd_r;
  otcps_pkg::otcps_elem_t rd_nxt;

  // masked groups keep their old content
  always_ff @(posedge core_clk) begin
    if (wr_en && int'(wr_addr) < DEPTH) begin
      mem[wr_addr] <= (mem[wr_addr] & ~wr_bit_en) | (wr_data & wr_bit_en);
    end
  end

  // read data, zero beyond the window
  always_comb begin
    rd_nxt = '0;
    if (int'(rd_addr) < DEPTH) begin
      rd_nxt = mem[rd_addr];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign rd_data = rd_r;

endmodule
`default_nettype wire

/* hdl/otcps_elem_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// turns a stored element into render controls
module otcps_elem_decode (
  // stored element and boundary
  input wire otcps_pkg::otcps_elem_t elem,
  input wire logic [8:0] boundary,
  // decoded controls
  output otcps_pkg::otcps_render_t attr
);

  always_comb begin
    attr = '0;
    // blink mode split into one-hot controls
    attr.fore_blink = (elem.blink == otcps_pkg::OTCPS_BLINK_FORE);
    attr.inverse = (elem.blink == otcps_pkg::OTCPS_BLINK_INVERSE);
    attr.swap_blink = (elem.blink == otcps_pkg::OTCPS_BLINK_SWAP);
    attr.shadow_on = elem.shadow;
    attr.back_see_through = elem.back_see_through;
    attr.fore_see_through = elem.fore_see_through;
    attr.back_blend_on = elem.back_blend_on;
    attr.fore_blend_on = elem.fore_blend_on;
    attr.back_colour_index = elem.back_colour_index;
    // only font ram codes at or above the boundary are multicolour
    attr.multicolour = !elem.font_rom && (elem.char_code >= boundary);
    // shared field: colour for single colour, palette of four for multicolour
    attr.fore_colour_index = attr.multicolour ? 3'h0 : elem.fore_colour_index;
    attr.palette_index = attr.multicolour ? elem.fore_colour_index : 3'h0;
    attr.font_rom = elem.font_rom;
    attr.char_code = elem.char_code;
  end

endmodule
`default_nettype wire

/* test/otcps_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the byte register port, strobes changed at the falling edge
module otcps_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data
);
  // idle port at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end
  // one byte write, data scrambled once released so a stale byte never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_wr_data = ~d;
  endtask
  // one byte read request
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
  endtask
  // one element: every property register that the write mode enables is written
  task automatic elem(input logic [2:0] wm, input logic [22:0] e);
    if (wm[2]) wr(8'h00, {1'b0, e[22:16]});
    if (wm[1]) wr(8'h01, e[15:8]);
    if (wm[0]) wr(8'h02, e[7:0]);
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the character property store
module tb;
  logic core_clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid, elem_committed, render_req, render_valid;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, back_blend_factor, fore_blend_factor, flt;
  logic [9:0] render_addr;
  logic [8:0] bnd;
  logic [22:0] pr, e;
  logic [22:0] mem [0:63];
  logic [7:0] rd_q[$];
  otcps_pkg::otcps_render_t render_attr;
  otcps_pkg::otcps_render_t rn_q[$];
  int err_total, cmp_count, commits, exp_commits, col, row, cols, rows;
  logic [7:0] ra [10] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
  logic [7:0] rv [10] = '{8'hff, 8'h00, 8'h00, 8'h20, 8'h10, 8'h01, 8'h00, 8'h80, 8'h80, 8'h00};

  otcps_char_store #(.DEPTH(1024)) otcps_char_store_i (.core_clk(core_clk), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .elem_committed(elem_committed),
    .render_req(render_req), .render_addr(render_addr), .render_attr(render_attr),
    .render_valid(render_valid), .back_blend_factor(back_blend_factor), .fore_blend_factor(fore_blend_factor));
  otcps_host_model otcps_host_model_i (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data));

  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // expected render controls of a stored element
  function automatic otcps_pkg::otcps_render_t dec(input logic [22:0] v);
    otcps_pkg::otcps_elem_t s;
    otcps_pkg::otcps_render_t r;
    s = v;
    r = '0;
    r.fore_blink = (s.blink == 2'h1);
    r.inverse = (s.blink == 2'h2);
    r.swap_blink = (s.blink == 2'h3);
    r.shadow_on = s.shadow;
    r.back_see_through = s.back_see_through;
    r.fore_see_through = s.fore_see_through;
    r.back_blend_on = s.back_blend_on;
    r.fore_blend_on = s.fore_blend_on;
    r.back_colour_index = s.back_colour_index;
    r.multicolour = !s.font_rom && (s.char_code >= bnd);
    r.fore_colour_index = r.multicolour ? 3'h0 : s.fore_colour_index;
    r.palette_index = r.multicolour ? s.fore_colour_index : 3'h0;
    r.font_rom = s.font_rom;
    r.char_code = s.char_code;
    return r;
  endfunction
  // read with expected byte noted
  task automatic rdx(input logic [7:0] a, input logic [7:0] x);
    rd_q.push_back(x);
    otcps_host_model_i.rd(a);
  endtask
  // render request with expected controls noted, address scrambled once released
  task automatic rnx(input int a);
    @(negedge core_clk);
    rn_q.push_back(dec(mem[a]));
    render_req = 1'b1;
    render_addr = 10'(a);
    @(negedge core_clk);
    render_req = 1'b0;
    render_addr = ~render_addr;
  endtask
  // filter and cursor setup
  task automatic setf(input logic [7:0] f);
    otcps_host_model_i.wr(8'h03, f);
    flt = f;
  endtask
  task automatic cur(input int c, input int r);
    otcps_host_model_i.wr(8'h04, 8'(c));
    otcps_host_model_i.wr(8'h05, 8'(r));
    col = c;
    row = r;
  endtask
  // one element through the enabled registers, with the expected store and cursor move
  task automatic put(input logic [22:0] v);
    logic [22:0] msk;
    int a;
    a = row * cols + col;
    msk = {{2{flt[7]}}, flt[6], flt[5], flt[4], flt[5], flt[4], {3{flt[5]}}, {3{flt[4]}}, {10{flt[3]}}};
    if (flt[2]) pr[22:16] = v[22:16];
    if (flt[1]) pr[15:8] = v[15:8];
    if (flt[0]) pr[7:0] = v[7:0];
    otcps_host_model_i.elem(flt[2:0], pr);
    if (flt[2:0] != 3'h0) begin
      mem[a] = (pr & msk) | (mem[a] & ~msk);
      exp_commits++;
      if (col + 1 < cols) col++;
      else begin
        col = 0;
        row = (row + 1 < rows) ? row + 1 : 0;
      end
    end
  endtask
  // end of a test: let answers land, then compare the commit count
  task automatic fin(input int n);
    repeat (4) @(negedge core_clk);
    check(commits, exp_commits);
    $display("test %0d done", n);
  endtask
  task automatic complete_run();
    check(rd_q.size() + rn_q.size(), 0);
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // result watcher: oldest note against each answer
  always @(negedge core_clk) begin
    if (reg_rd_valid === 1'b1) check(reg_rd_data, rd_q.pop_front());
    if (render_valid === 1'b1) check(render_attr, rn_q.pop_front());
    if (elem_committed === 1'b1) commits++;
  end
  // watchdog
  initial begin
    #2000000;
    err_total++;
    complete_run();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    render_req = 1'b0;
    render_addr = 10'h000;
    flt = 8'hff;
    bnd = 9'h100;
    pr = 23'h0;
    cols = 32;
    rows = 16;
    void'($urandom(88734));
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    // test 1: reset values, unmapped read
    check(back_blend_factor, 8'h80);
    check(fore_blend_factor, 8'h80);
    foreach (ra[i]) rdx(ra[i], rv[i]);
    fin(1);
    // test 2: full write mode, every blink code, readback and cursor
    for (int i = 0; i < 4; i++) begin
      e = 23'($urandom());
      e[22:21] = 2'(i);
      put(e);
    end
    for (int i = 0; i < 4; i++) rnx(i);
    rdx(8'h04, 8'h04);
    rdx(8'h05, 8'h00);
    fin(2);
    // test 3: code group only, code-low write mode
    setf(8'h09);
    cur(0, 0);
    put({pr[22:8], 8'h41});
    rnx(0);
    rdx(8'h04, 8'h01);
    fin(3);
    // test 4: multicolour boundary and row advance
    otcps_host_model_i.wr(8'h08, 8'h00);
    otcps_host_model_i.wr(8'h09, 8'h40);
    bnd = 9'h040;
    setf(8'hfb);
    cur(31, 0);
    put({pr[22:16], 8'ha8, 8'h50});
    put({pr[22:16], 8'ha8, 8'h30});
    rnx(31);
    rnx(32);
    rdx(8'h04, 8'h01);
    rdx(8'h05, 8'h01);
    otcps_host_model_i.wr(8'h0a, 8'h3c);
    otcps_host_model_i.wr(8'h0b, 8'hc3);
    @(negedge core_clk);
    check(back_blend_factor, 8'h3c);
    check(fore_blend_factor, 8'hc3);
    fin(4);
    // test 5: wrap at the last element, write mode 000 never commits
    otcps_host_model_i.wr(8'h06, 8'h02);
    otcps_host_model_i.wr(8'h07, 8'h02);
    cols = 2;
    rows = 2;
    setf(8'h01);
    cur(1, 1);
    put(23'($urandom()));
    rdx(8'h04, 8'h00);
    rdx(8'h05, 8'h00);
    setf(8'h00);
    put(23'($urandom()));
    rdx(8'h04, 8'h00);
    // flags-only and colour-only write modes with partial filters
    setf(8'hc4);
    put(23'($urandom()));
    setf(8'h32);
    put(23'($urandom()));
    rnx(0);
    rnx(1);
    rdx(8'h05, 8'h01);
    rdx(8'h00, {1'b0, pr[22:16]});
    fin(5);
    complete_run();
  end
endmodule
`default_nettype wire
